// [dv/serial_peer.sv]
// remote serial node: drives the receive line, captures the transmit line
`timescale 1ns/1ps
module serial_peer #(
  parameter int BIT_CLKS = 16,
  parameter int EXT_HALF = 2
) (
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o,
  output logic ext_clk_o
);
  initial rxd_o = 1'b1;
  // external 16x clock; stopping it upsets the unit, so it runs free
  initial begin
    ext_clk_o = 1'b0;
    forever begin
      repeat (EXT_HALF) @(negedge clk_i);
      ext_clk_o = ~ext_clk_o;
    end
  end
  // lsb of bits goes out first; line back to mark afterwards
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rxd_o = bits[i];
      repeat (BIT_CLKS) @(negedge clk_i);
    end
    rxd_o = 1'b1;
  endtask
  // samples mid-bit; returns mid last bit so a following start is not missed
  task automatic grab(input int n, output logic [11:0] bits, output logic ok);
    int t;
    t = 0;
    bits = '0;
    while (txd_i !== 1'b0 && t < 4000) begin
      @(negedge clk_i);
      t++;
    end
    ok = (t < 4000);
    repeat (BIT_CLKS / 2) @(negedge clk_i);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd_i;
      if (i < n - 1) repeat (BIT_CLKS) @(negedge clk_i);
    end
  endtask
endmodule

// [dv/testbench.sv]
// self-checking bench for the asynchronous serial unit
`timescale 1ns/1ps
module testbench;
  import serial_unit_pkg::*;
  localparam int BT = 16;
  logic clk, rst, tx_en, rx_en, irqen, wr, mps, tclr, mpset, fclr, rxd, ok, eck;
  logic [1:0] csrc;
  logic txd, txoe, sck, sckoe, tempty, tx_end_flag, rfull, mprx, mpen, ti, tx_end_irq, ri, ei;
  logic [7:0] txd_data, rxdata;
  logic [11:0] fb, got, exp1;
  frame_fmt_type fmt;
  rx_err_type eclr, err;
  int fn, t, n_errors, total_checks;

  serial_unit i_dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .CLK_SRC_I(csrc),
    .BIT_RATE_I(8'h00), .FMT_I(fmt), .TX_EN_I(tx_en), .RX_EN_I(rx_en),
    .RX_IRQ_EN_I(irqen), .TX_EMPTY_IRQ_EN_I(irqen), .TX_END_IRQ_EN_I(irqen),
    .MP_IRQ_EN_SET_I(mpset), .EXT_CLK_I(eck), .TX_DATA_I(txd_data), .TX_DATA_WR_I(wr),
    .TX_EMPTY_CLR_I(tclr), .MP_BIT_SEND_I(mps), .RX_FULL_CLR_I(fclr), .ERR_CLR_I(eclr),
    .RXD_I(rxd), .TXD_O(txd), .TXD_OE_O(txoe), .SCK_O(sck), .SCK_OE_O(sckoe),
    .TX_EMPTY_O(tempty), .TX_END_O(tx_end_flag), .RX_FULL_O(rfull), .ERR_O(err),
    .RX_DATA_O(rxdata), .MP_BIT_RX_O(mprx), .MP_IRQ_EN_O(mpen), .TX_EMPTY_IRQ_O(ti),
    .TX_END_IRQ_O(tx_end_irq), .RX_FULL_IRQ_O(ri), .RX_ERR_IRQ_O(ei));
  serial_peer #(.BIT_CLKS(BT)) i_peer (.clk_i(clk), .txd_i(txd), .rxd_o(rxd),
    .ext_clk_o(eck));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [11:0] s, input logic [11:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  task automatic clr();
    fclr = 1'b1;
    eclr = '1;
    @(negedge clk);
    fclr = 1'b0;
    eclr = '0;
  endtask

  // expected line bits, start first; x is the mp bit or a parity flip
  task automatic mk(input frame_fmt_type f, input logic [7:0] d, input logic x);
    logic p;
    p = f.parity_odd ^ x;
    fb = '1;
    fb[0] = 1'b0;
    fn = f.seven_bit ? 8 : 9;
    for (int i = 1; i < fn; i++) begin
      fb[i] = d[i-1];
      p = p ^ d[i-1];
    end
    if (f.multiproc || f.parity_en) begin
      fb[fn] = f.multiproc ? x : p;
      fn++;
    end
    fn += f.two_stop ? 2 : 1;
    fb &= (12'h001 << fn) - 12'h001;
  endtask

  task automatic s_tx(input frame_fmt_type f, input logic [7:0] d, input logic x);
    fmt = f;
    mk(f, d, x);
    txd_data = d;
    pulse(wr);
    if (x) pulse(mps);
    fork
      i_peer.grab(fn, got, ok);
      begin
        pulse(tclr);
        repeat (3) @(negedge clk);
        chk("tx_empty", {tempty, ti, tx_end_flag}, 3'b110);
      end
    join
    chk("tx_start", ok, 1);
    chk("tx_frame", got, fb);
    repeat (BT) @(negedge clk);
    chk("tx_end", {tx_end_flag, tx_end_irq, txd}, 3'b111);
  endtask

  task automatic s_b2b();
    fmt = '0;
    mk(fmt, 8'hc1, 1'b0);
    exp1 = fb;
    txd_data = 8'hc1;
    pulse(wr);
    fork
      begin
        i_peer.grab(fn, fb, ok);
        t = 0;
        while (txd !== 1'b0 && t < BT) begin
          @(negedge clk);
          t++;
        end
        i_peer.grab(fn, got, ok);
      end
      begin
        pulse(tclr);
        repeat (4) @(negedge clk);
        txd_data = 8'h3e;
        pulse(wr);
        pulse(tclr);
      end
    join
    chk("b2b_first", fb, exp1);
    chk("b2b_gap", t <= BT / 2 + 2, 1);
    mk(fmt, 8'h3e, 1'b0);
    chk("b2b_second", got, fb);
    repeat (2 * BT) @(negedge clk);
  endtask

  task automatic s_txoff();
    txd_data = 8'h00;
    pulse(wr);
    pulse(tclr);
    repeat (4) @(negedge clk);
    pulse(wr);
    pulse(tclr);
    chk("pending", tempty, 0);
    repeat (BT) @(negedge clk);
    tx_en = 1'b0;
    repeat (2) @(negedge clk);
    chk("tx_off", {tempty, txoe}, 2'b10);
    tx_en = 1'b1;
    t = 0;
    repeat (3 * BT) begin
      @(negedge clk);
      t += (txd !== 1'b1);
    end
    chk("tx_off_idle", t, 0);
  endtask

  // external 16x clock: one bit lasts four times as many system clocks
  task automatic s_ext();
    tx_en = 1'b0;
    csrc = 2'h2;
    repeat (4 * BT) @(negedge clk);
    chk("ext_sck", sckoe, 0);
    tx_en = 1'b1;
    fmt = '0;
    txd_data = 8'h01;
    pulse(wr);
    pulse(tclr);
    t = 0;
    while (txd !== 1'b0 && t < 8) begin
      @(negedge clk);
      t++;
    end
    t = 0;
    while (txd === 1'b0 && t < 200) begin
      @(negedge clk);
      t++;
    end
    chk("ext_start", (t >= 4 * BT - 3) && (t <= 4 * BT), 1);
    repeat (40 * BT) @(negedge clk);
    chk("ext_end", {tx_end_flag, txd}, 2'b11);
    csrc = CKSRC_INT_OUT;
  endtask

  task automatic s_rx(input frame_fmt_type f, input logic [7:0] d, input logic x,
      input logic brk, input logic [11:0] e);
    fmt = f;
    mk(f, d, x);
    if (brk) fb[fn - 1 - int'(f.two_stop)] = 1'b0;
    i_peer.send(fb, fn);
    repeat (2) @(negedge clk);
    chk("rx", {rfull, err, rxdata}, e);
    chk("rx_irq", {ri, ei}, {e[11], |e[10:8]});
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    $display("[ERR] watchdog ran out");
    stop_test();
  end

  initial begin
    {rst, irqen} = 2'b11;
    {tx_en, rx_en, wr, mps, tclr, mpset, fclr} = '0;
    {fmt, eclr, txd_data} = '0;
    csrc = CKSRC_INT_OUT;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("sck_out", {sckoe, txd}, 2'b11);
    t = 0;
    repeat (2 * BT) begin
      ok = sck;
      @(negedge clk);
      t += (sck && !ok);
    end
    chk("sck_rate", t, 2);
    tx_en = 1'b1;
    rx_en = 1'b1;
    @(negedge clk);
    chk("idle", {txd, txoe}, 2'b11);
    s_tx(5'b00000, 8'ha5, 1'b0);
    s_tx(5'b01000, 8'h6d, 1'b0);
    s_tx(5'b11101, 8'h3a, 1'b0);
    s_tx(5'b01110, 8'h96, 1'b1);
    s_tx(5'b00010, 8'h0f, 1'b0);
    s_tx(5'b10011, 8'h55, 1'b1);
    s_b2b();
    s_txoff();
    s_ext();
    s_rx(5'b01000, 8'h3c, 1'b0, 1'b0, {4'h8, 8'h3c});
    irqen = 1'b0;
    @(negedge clk);
    chk("rx_irq_mask", ri, 0);
    irqen = 1'b1;
    s_rx(5'b01000, 8'h5a, 1'b0, 1'b0, {4'hc, 8'h3c});
    s_rx(5'b01000, 8'h11, 1'b0, 1'b0, {4'hc, 8'h3c});
    clr();
    s_rx(5'b01000, 8'h81, 1'b1, 1'b0, {4'h1, 8'h81});
    clr();
    s_rx(5'b11101, 8'h2b, 1'b0, 1'b1, {4'h2, 8'h2b});
    clr();
    s_rx(5'b10001, 8'hff, 1'b0, 1'b0, {4'h8, 8'h7f});
    clr();
    fmt = 5'b00010;
    pulse(mpset);
    s_rx(5'b00010, 8'h44, 1'b0, 1'b0, {4'h0, 8'h7f});
    chk("mp_skip", mpen, 1);
    s_rx(5'b00010, 8'h07, 1'b1, 1'b0, {4'h8, 8'h07});
    chk("mp_id", {mprx, mpen}, 2'b10);
    stop_test();
  end
endmodule

// [hw/serial_unit.sv]
// asynchronous serial unit: transmitter, receiver, flags and interrupt requests
// How it works
// - bit-rate clock output starts once clock source is set, before enables
// - enabling hands pins to unit: transmitter idles high, receiver waits start
// - software clearing tx-empty flag makes unit load holding into shift register
// - after load, tx-empty flag sets, sending begins, tx-empty irq if enabled
// - frame starts with low start bit, then 7 or 8 data bits LSB first
// - then parity bit, multiprocessor bit, or nothing per format
// - one or two high stop bits, then line held high
// - tx-empty flag 0 at stop bit: next byte loaded, next frame follows
// - tx-empty flag 1 at stop bit: tx-end flag set, line high, irq
// - receiver syncs on start bit, shifts data in LSB first
// - receive parity checked against even or odd setting
// - first stop bit must be 1; second is not checked
// - all checks pass: shift register copied to holding, rx-full set
// - frame done with rx-full still set: overrun, holding unchanged
// - stop 0 sets framing error, parity mismatch parity error; data still copied
// - any error flag set halts reception and blocks rx-full
// - with rx irq enable: rx-full irq and error irq
// - id frames carry multiprocessor bit 1, data frames 0
// - multiprocessor format ignores parity settings, sends no parity
// - 16x serial clock, align on start falling edge, sample at 8th cycle
// - clearing transmit enable sets tx-empty and resets shift register
`timescale 1ns/1ps
module serial_unit
  import serial_unit_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [1:0] CLK_SRC_I,
  input wire logic [DIV_W-1:0] BIT_RATE_I,
  input wire frame_fmt_type FMT_I,
  input wire logic TX_EN_I,
  input wire logic RX_EN_I,
  input wire logic RX_IRQ_EN_I,
  input wire logic TX_EMPTY_IRQ_EN_I,
  input wire logic TX_END_IRQ_EN_I,
  input wire logic MP_IRQ_EN_SET_I,
  input wire logic EXT_CLK_I,
  input wire logic [7:0] TX_DATA_I,
  input wire logic TX_DATA_WR_I,
  input wire logic TX_EMPTY_CLR_I,
  input wire logic MP_BIT_SEND_I,
  input wire logic RX_FULL_CLR_I,
  input wire rx_err_type ERR_CLR_I,
  input wire logic RXD_I,
  output logic TXD_O,
  output logic TXD_OE_O,
  output logic SCK_O,
  output logic SCK_OE_O,
  output logic TX_EMPTY_O,
  output logic TX_END_O,
  output logic RX_FULL_O,
  output rx_err_type ERR_O,
  output logic [7:0] RX_DATA_O,
  output logic MP_BIT_RX_O,
  output logic MP_IRQ_EN_O,
  output logic TX_EMPTY_IRQ_O,
  output logic TX_END_IRQ_O,
  output logic RX_FULL_IRQ_O,
  output logic RX_ERR_IRQ_O
);
  // pin synchronisers
  logic rxd_s1_ff, rxd_s2_ff, ext_s1_ff, ext_s2_ff, ext_d_ff;
  always_ff @(posedge SYS_CLK_I) begin
    rxd_s1_ff <= RXD_I;
    rxd_s2_ff <= rxd_s1_ff;
    ext_s1_ff <= EXT_CLK_I;
    ext_s2_ff <= ext_s1_ff;
    ext_d_ff <= ext_s2_ff;
  end

  // 16x tick: internal divider or external clock rising edge
  logic [DIV_W-1:0] div_ff;
  logic [3:0] sck_ph_ff;
  logic sck_ff;
  wire use_ext = CLK_SRC_I[1];
  wire div_done = (div_ff == BIT_RATE_I);
  wire tick = use_ext ? (ext_s2_ff & ~ext_d_ff) : div_done;
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      div_ff <= '0;
      sck_ph_ff <= 4'h0;
      sck_ff <= 1'b0;
    end else begin
      div_ff <= div_done ? '0 : div_ff + 1'b1;
      if (tick) begin
        sck_ph_ff <= sck_ph_ff + 4'h1;
        sck_ff <= (sck_ph_ff >= SAMPLE_PHASE) && (sck_ph_ff != LAST_PHASE);
      end
    end
  end
  // runs off the clock source setting alone, independent of the enables
  assign SCK_OE_O = (CLK_SRC_I == CKSRC_INT_OUT);
  assign SCK_O = sck_ff;

  function automatic logic odd_ones(input logic [7:0] d, input logic seven);
    odd_ones = ^(seven ? {1'b0, d[6:0]} : d);
  endfunction

  // transmitter
  tx_state_type tx_st_ff;
  logic [7:0] hold_ff, tsr_ff;
  logic [3:0] tx_ph_ff;
  logic [2:0] tx_cnt_ff;
  logic tx_empty_ff, tx_end_ff, txd_ff, tx_mpb_ff, tx_stop2_ff, mp_send_ff;
  wire tx_bit_end = tick && (tx_ph_ff == LAST_PHASE);
  wire [2:0] last_bit = FMT_I.seven_bit ? 3'h6 : 3'h7;
  wire has_extra = FMT_I.multiproc | FMT_I.parity_en;
  wire extra_bit = FMT_I.multiproc ? tx_mpb_ff
                 : (odd_ones(tsr_ff, FMT_I.seven_bit) ^ FMT_I.parity_odd);
  wire tx_load_now = TX_EN_I && !tx_empty_ff && (tx_st_ff == TX_IDLE);
  wire tx_stop_last = (tx_st_ff == TX_STOP) && tx_bit_end
                    && (!FMT_I.two_stop || tx_stop2_ff);
  wire tx_chain = tx_stop_last && !tx_empty_ff;
  // disable wins over a chained load, so gate both load paths with the enable
  wire tx_load = TX_EN_I && (tx_load_now || tx_chain);
  wire tx_end_set = tx_stop_last && tx_empty_ff;

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      tx_st_ff <= TX_IDLE;
      hold_ff <= RST_DATA;
      tsr_ff <= RST_DATA;
      tx_ph_ff <= 4'h0;
      tx_cnt_ff <= 3'h0;
      tx_empty_ff <= 1'b1;
      tx_end_ff <= 1'b1;
      txd_ff <= 1'b1;
      tx_mpb_ff <= 1'b0;
      tx_stop2_ff <= 1'b0;
      mp_send_ff <= 1'b0;
    end else if (!TX_EN_I) begin
      tx_st_ff <= TX_IDLE;
      tsr_ff <= RST_DATA;
      tx_empty_ff <= 1'b1;
      tx_end_ff <= 1'b1;
      txd_ff <= 1'b1;
      if (TX_DATA_WR_I) hold_ff <= TX_DATA_I;
      if (MP_BIT_SEND_I) mp_send_ff <= 1'b1;
    end else begin
      if (TX_DATA_WR_I) hold_ff <= TX_DATA_I;
      if (TX_DATA_WR_I) mp_send_ff <= 1'b0;
      if (MP_BIT_SEND_I) mp_send_ff <= 1'b1;
      if (TX_EMPTY_CLR_I) tx_empty_ff <= 1'b0;
      if (tx_load) begin
        tsr_ff <= hold_ff;
        tx_mpb_ff <= mp_send_ff;
        tx_empty_ff <= 1'b1;
        tx_end_ff <= 1'b0;
        tx_st_ff <= TX_START;
        tx_ph_ff <= 4'h0;
        txd_ff <= 1'b0;
      end else begin
        if (tx_end_set) tx_end_ff <= 1'b1;
        if (tick && tx_st_ff != TX_IDLE) tx_ph_ff <= tx_ph_ff + 4'h1;
        if (tx_bit_end) begin
          case (tx_st_ff)
            TX_START: begin
              tx_st_ff <= TX_DATA;
              tx_cnt_ff <= 3'h0;
              txd_ff <= tsr_ff[0];
            end
            TX_DATA: begin
              if (tx_cnt_ff == last_bit) begin
                tx_st_ff <= has_extra ? TX_EXTRA : TX_STOP;
                txd_ff <= has_extra ? extra_bit : 1'b1;
                tx_stop2_ff <= 1'b0;
              end else begin
                tx_cnt_ff <= tx_cnt_ff + 3'h1;
                txd_ff <= tsr_ff[tx_cnt_ff + 3'h1];
              end
            end
            TX_EXTRA: begin
              tx_st_ff <= TX_STOP;
              txd_ff <= 1'b1;
              tx_stop2_ff <= 1'b0;
            end
            TX_STOP: begin
              txd_ff <= 1'b1;
              if (tx_stop_last) tx_st_ff <= TX_IDLE;
              else tx_stop2_ff <= 1'b1;
            end
            default: tx_st_ff <= TX_IDLE;
          endcase
        end
      end
    end
  end
  // port owns the pin when disabled, so a break comes from port logic
  assign TXD_OE_O = TX_EN_I;
  assign TXD_O = txd_ff;
  assign TX_EMPTY_O = tx_empty_ff;
  assign TX_END_O = tx_end_ff;
  assign TX_EMPTY_IRQ_O = TX_EMPTY_IRQ_EN_I & tx_empty_ff & TX_EN_I;
  assign TX_END_IRQ_O = TX_END_IRQ_EN_I & tx_end_ff & TX_EN_I;

  // receiver
  rx_state_type rx_st_ff;
  logic [7:0] rsr_ff, rdr_ff;
  logic [3:0] rx_ph_ff;
  logic [2:0] rx_cnt_ff;
  logic rx_full_ff, rx_extra_ff, rx_mpb_ff, multiproc_irq_enable_ff;
  rx_err_type err_ff;
  wire any_err = |err_ff;
  wire rx_sample = tick && (rx_ph_ff == SAMPLE_PHASE);
  // seven-bit data sits in the top of the shift register
  wire [7:0] rx_byte = FMT_I.seven_bit ? {1'b0, rsr_ff[7:1]} : rsr_ff;
  wire par_bad = FMT_I.parity_en && !FMT_I.multiproc
               && ((odd_ones(rx_byte, 1'b0) ^ rx_extra_ff) != FMT_I.parity_odd);
  wire frame_done = (rx_st_ff == RX_STOP) && rx_sample;
  wire stop_bad = !rxd_s2_ff;
  wire mp_skip = multiproc_irq_enable_ff && FMT_I.multiproc && !rx_extra_ff;
  wire rx_accept = frame_done && !mp_skip;
  wire ovr = rx_accept && rx_full_ff;

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      rx_st_ff <= RX_IDLE;
      rsr_ff <= RST_DATA;
      rdr_ff <= RST_DATA;
      rx_ph_ff <= 4'h0;
      rx_cnt_ff <= 3'h0;
      rx_full_ff <= 1'b0;
      rx_extra_ff <= 1'b0;
      rx_mpb_ff <= 1'b0;
      multiproc_irq_enable_ff <= 1'b0;
      err_ff <= '0;
    end else begin
      // hardware set wins over software clear
      if (RX_FULL_CLR_I) rx_full_ff <= 1'b0;
      err_ff <= err_ff & ~ERR_CLR_I;
      if (MP_IRQ_EN_SET_I) multiproc_irq_enable_ff <= 1'b1;
      if (tick) rx_ph_ff <= rx_ph_ff + 4'h1;
      if (!RX_EN_I || any_err) begin
        rx_st_ff <= any_err ? RX_HALT : RX_IDLE;
        if (!any_err && rx_st_ff == RX_HALT) rx_st_ff <= RX_IDLE;
      end else begin
        case (rx_st_ff)
          RX_IDLE: if (!rxd_s2_ff) begin
            rx_st_ff <= RX_START;
            rx_ph_ff <= 4'h0;
            rx_cnt_ff <= 3'h0;
          end
          RX_START: if (rx_sample) rx_st_ff <= rxd_s2_ff ? RX_IDLE : RX_DATA;
          RX_DATA: if (rx_sample) begin
            rsr_ff <= {rxd_s2_ff, rsr_ff[7:1]};
            rx_cnt_ff <= rx_cnt_ff + 3'h1;
            if (rx_cnt_ff == last_bit) begin
              rx_cnt_ff <= 3'h0;
              rx_st_ff <= has_extra ? RX_EXTRA : RX_STOP;
              rx_extra_ff <= 1'b0;
            end
          end
          RX_EXTRA: if (rx_sample) begin
            rx_extra_ff <= rxd_s2_ff;
            rx_st_ff <= RX_STOP;
          end
          RX_STOP: if (rx_sample) begin
            rx_st_ff <= RX_IDLE;
            if (rx_accept) begin
              if (FMT_I.multiproc && rx_extra_ff) multiproc_irq_enable_ff <= 1'b0;
              rx_mpb_ff <= rx_extra_ff;
              if (ovr) begin
                err_ff.overrun <= 1'b1;
              end else begin
                rdr_ff <= rx_byte;
                err_ff.framing <= stop_bad;
                err_ff.parity <= par_bad;
                rx_full_ff <= !(stop_bad || par_bad);
              end
            end
          end
          default: rx_st_ff <= RX_IDLE;
        endcase
      end
    end
  end
  assign RX_DATA_O = rdr_ff;
  assign RX_FULL_O = rx_full_ff;
  assign ERR_O = err_ff;
  assign MP_BIT_RX_O = rx_mpb_ff;
  assign MP_IRQ_EN_O = multiproc_irq_enable_ff;
  assign RX_FULL_IRQ_O = RX_IRQ_EN_I & rx_full_ff;
  assign RX_ERR_IRQ_O = RX_IRQ_EN_I & any_err;

  a_tx_load_sets: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    tx_load |=> tx_empty_ff && !TXD_O) else $error("load did not start frame");
  a_tx_dis_empty: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    !TX_EN_I |=> tx_empty_ff && TXD_O) else $error("tx disable left state");
  a_tx_end_hi: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    tx_end_set |=> tx_end_ff && TXD_O) else $error("tx end not set");
  a_tx_idle_mark: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (tx_st_ff == TX_IDLE) |-> TXD_O) else $error("idle line not high");
  a_rx_ovr_keep: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    ovr && RX_EN_I && !any_err |=> err_ff.overrun && $stable(rdr_ff)) else $error("overrun");
  a_rx_halt_full: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    any_err && !RX_FULL_CLR_I && !rx_full_ff |=> !rx_full_ff) else $error("full set in error");
  a_rx_err_irq: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    rx_accept && RX_EN_I && !any_err && (stop_bad || par_bad || rx_full_ff)
    |=> RX_ERR_IRQ_O || !RX_IRQ_EN_I) else $error("error irq missing");
  a_sck_out_en: assert property (@(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (CLK_SRC_I == CKSRC_INT_OUT) && tick && (sck_ph_ff == SAMPLE_PHASE)
    |=> SCK_O) else $error("clock output not rising");
endmodule

// [include/serial_unit_pkg.sv]
// package: constants and types for the asynchronous serial unit
package serial_unit_pkg;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] SAMPLE_PHASE = 4'h7;
  localparam logic [3:0] LAST_PHASE = 4'hf;
  localparam logic [7:0] RST_BIT_RATE = 8'hff;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [1:0] CKSRC_INT_PORT = 2'h0;
  localparam logic [1:0] CKSRC_INT_OUT = 2'h1;

  typedef struct packed {
    logic seven_bit;
    logic parity_en;
    logic parity_odd;
    logic multiproc;
    logic two_stop;
  } frame_fmt_type;

  typedef struct packed {
    logic overrun;
    logic framing;
    logic parity;
  } rx_err_type;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_START = 3'h1,
    TX_DATA = 3'h3,
    TX_EXTRA = 3'h2,
    TX_STOP = 3'h6
  } tx_state_type;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h0,
    RX_START = 3'h1,
    RX_DATA = 3'h3,
    RX_EXTRA = 3'h2,
    RX_STOP = 3'h6,
    RX_HALT = 3'h7
  } rx_state_type;
endpackage
